/* File: cws_params.svh */
// Offsets, field positions, reset values and timing counts of the control write sequencer
`ifndef CWS_PARAMS_SVH
`define CWS_PARAMS_SVH

// Register offsets on the serial control interface
`define CWS_ADDR_SETUP    8'h46
`define CWS_ADDR_STEP_A   8'h47
`define CWS_ADDR_STEP_B   8'h48
`define CWS_ADDR_COMMAND  8'h49
`define CWS_ADDR_BUSY     8'h4a
`define CWS_ADDR_POSITION 8'h4b

// Setup register fields
`define CWS_ON_BIT        8
`define CWS_WRPOS_MSB     4
// Step register A fields
`define CWS_WIDTH_MSB     14
`define CWS_WIDTH_LSB     12
`define CWS_FLSB_MSB      11
`define CWS_FLSB_LSB      8
`define CWS_TARGET_MSB    7
// Step register B fields
`define CWS_END_BIT       14
`define CWS_WAIT_MSB      11
`define CWS_WAIT_LSB      8
`define CWS_VALUE_MSB     7
// Command register fields
`define CWS_ABORT_BIT     9
`define CWS_GO_BIT        8
`define CWS_FIRST_MSB     5
// Busy register field
`define CWS_RUN_BIT       0

// Index map of the step memory
`define CWS_RAM_LAST      6'h1f
`define CWS_ROM_FIRST     6'h20
`define CWS_ROM_LAST      6'h3a
`define CWS_ROM_DEPTH     27

// Reset values
`define CWS_RST_INDEX     6'h00
`define CWS_RST_WRPOS     5'h00
`define CWS_RST_STEP      15'h0000

// Step timing: one unit is 62.5 us, a step lasts unit * (2^code + 8)
`define CWS_UNIT_PS       62500000
`define CWS_CLK_PS        5000
`define CWS_UNIT_CYCLES   (`CWS_UNIT_PS / `CWS_CLK_PS)
`define CWS_UNIT_BASE     16'h0008

`endif

/* File: cws_pkg.sv */
// Types shared by the control write sequencer
package cws_pkg;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    CWS_IDLE   = 6'b000001,
    CWS_FETCH  = 6'b000010,
    CWS_READ   = 6'b000100,
    CWS_MODIFY = 6'b001000,
    CWS_WRITE  = 6'b010000,
    CWS_WAIT   = 6'b100000
  } cws_state_e;

  // One decoded step of the sequence memory
  typedef struct packed {
    logic       end_flag;    // step_end_flag
    logic [3:0] wait_code;   // step_wait_code
    logic [2:0] width;       // step_field_width
    logic [3:0] field_lsb;   // step_field_lsb
    logic [7:0] target;      // step_target_reg
    logic [7:0] value;       // step_value
  } cws_step_s;

  // Host request from the serial control interface decoder
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cws_host_req_s;

  // Write or read toward the control register bank
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cws_bank_req_s;

endpackage : cws_pkg

/* File: cws_sequencer.sv */
// Control write sequencer: command registers, step memory and step engine
`timescale 1ns/10ps
`include "cws_params.svh"

// Summary of operation
// - Abort bit ends sequence, frees control port
// - Start bit begins at start index location
// - Execute steps until end-flagged step done
// - Start bit clears itself on completion
// - Six-bit start index: RAM, ROM, reserved
// - Read-only busy flag, high while running
// - Host control writes dropped while busy
// - Current index shows last fetched location
// - Step writes width-limited field at address
// - End flag halts after that step
// - Step time is unit times (2^D+8)
// - Step writes copied to RAM write index
module cws_sequencer #(
  parameter int unsigned UNIT_CYCLES = `CWS_UNIT_CYCLES  // Clock cycles per delay unit
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire cws_pkg::cws_host_req_s host_req,
  output logic [15:0]                 host_rdata,
  output cws_pkg::cws_bank_req_s      bank_req,
  input  wire logic [15:0]            bank_rdata,
  output logic                        seq_running_flag
);

  // All state of the block except the step RAM, registered as one word
  typedef struct packed {
    cws_pkg::cws_state_e    st;
    logic                   sequencer_on;        // Enable from the setup register
    logic [4:0]             step_ram_write_pos;  // RAM slot that step writes land in
    logic [14:0]            step_a;              // Shadow of step register A
    logic [14:0]            step_b;              // Shadow of step register B
    logic                   seq_go_cmd;          // Start bit, self-clearing
    logic [5:0]             seq_first_step;      // Start index
    logic [5:0]             seq_last_step_pos;   // Location of last fetched step
    logic [5:0]             next_pos;            // Location the next fetch uses
    logic                   running;             // Busy flag
    logic [13:0]            tick;                // Cycles within one delay unit
    logic [15:0]            units;               // Whole units elapsed in this step
    logic [15:0]            goal;                // Units this step must last
    cws_pkg::cws_step_s     cur;                 // Step being executed
    logic [15:0]            rdata;               // Host read answer
    cws_pkg::cws_bank_req_s bank;                // Request toward the register bank
  } cws_state_s;

  cws_state_s q;       // Registered state
  cws_state_s next_q;  // Next state

  // Step memory: writable RAM part, the ROM part is a constant table
  logic [27:0] step_ram [32];

  // Mask covering width+1 bits starting at the field LSB
  function automatic logic [15:0] field_mask(input logic [2:0] w, input logic [3:0] lsb);
    logic [15:0] ones;
    ones = 16'((17'h00002 << w) - 17'h00001);
    return 16'(ones << lsb);
  endfunction : field_mask

  // Build a memory word from the two step registers
  function automatic cws_pkg::cws_step_s pack_step(input logic [14:0] a, input logic [14:0] b);
    cws_pkg::cws_step_s s;
    s.end_flag  = b[`CWS_END_BIT];
    s.wait_code = b[`CWS_WAIT_MSB:`CWS_WAIT_LSB];
    s.width     = a[`CWS_WIDTH_MSB:`CWS_WIDTH_LSB];
    s.field_lsb = a[`CWS_FLSB_MSB:`CWS_FLSB_LSB];
    s.target    = a[`CWS_TARGET_MSB:0];
    s.value     = b[`CWS_VALUE_MSB:0];
    return s;
  endfunction : pack_step

  // Fixed ROM steps: each ends its sequence and clears bit 0 of register 0x00 (one-bit field of 0)
  function automatic cws_pkg::cws_step_s rom_step(input logic [5:0] pos);
    cws_pkg::cws_step_s s;
    s = '0;
    s.end_flag = (pos <= `CWS_ROM_LAST);
    return s;
  endfunction : rom_step

  // Host write strobes decoded per register
  logic wr_setup;
  logic wr_step_a;
  logic wr_step_b;
  logic wr_command;
  logic wr_other;
  logic unit_done;
  logic step_done;
  cws_pkg::cws_step_s fetched;

  // Address decode; only the command register stays writable while busy
  always_comb begin
    wr_command = host_req.wr && (host_req.addr == `CWS_ADDR_COMMAND);
    wr_setup   = host_req.wr && !q.running && (host_req.addr == `CWS_ADDR_SETUP);
    wr_step_a  = host_req.wr && !q.running && (host_req.addr == `CWS_ADDR_STEP_A);
    wr_step_b  = host_req.wr && !q.running && (host_req.addr == `CWS_ADDR_STEP_B);
    wr_other   = host_req.wr && !q.running && !(host_req.addr inside
                 {[`CWS_ADDR_SETUP:`CWS_ADDR_POSITION]});
  end

  // Step memory lookup and delay timer terminal counts
  always_comb begin
    if (q.next_pos <= `CWS_RAM_LAST) begin
      fetched = cws_pkg::cws_step_s'(step_ram[q.next_pos[4:0]]);
    end else begin
      fetched = rom_step(q.next_pos);
    end
    unit_done = (q.tick == 14'(UNIT_CYCLES - 1));
    step_done = unit_done && (q.units == q.goal - 16'h0001);
  end

  // Next-state logic for registers and the step engine
  always_comb begin
    next_q = q;
    next_q.bank.wr = 1'b0;
    next_q.bank.rd = 1'b0;
    // Setup register: enable and RAM write position
    if (wr_setup) begin
      next_q.sequencer_on       = host_req.wdata[`CWS_ON_BIT];
      next_q.step_ram_write_pos = host_req.wdata[`CWS_WRPOS_MSB:0];
    end
    // Step register shadows, read back by the host
    if (wr_step_a) begin
      next_q.step_a = host_req.wdata[14:0];
    end
    if (wr_step_b) begin
      next_q.step_b = host_req.wdata[14:0];
    end
    // Ordinary control writes pass to the bank only while idle
    if (wr_other) begin
      next_q.bank.wr    = 1'b1;
      next_q.bank.addr  = host_req.addr;
      next_q.bank.wdata = host_req.wdata;
    end
    // Delay timer runs from fetch to the end of the step
    if (!q.st[0]) begin
      next_q.tick = unit_done ? 14'h0000 : q.tick + 14'h0001;
      if (unit_done) begin
        next_q.units = q.units + 16'h0001;
      end
    end
    unique case (q.st)
      cws_pkg::CWS_IDLE: begin
        // Start only accepted when enabled; abort in the same write wins
        if (wr_command && !host_req.wdata[`CWS_ABORT_BIT]) begin
          next_q.seq_first_step = host_req.wdata[`CWS_FIRST_MSB:0];
          if (host_req.wdata[`CWS_GO_BIT] && q.sequencer_on) begin
            next_q.seq_go_cmd = 1'b1;
            next_q.running    = 1'b1;
            next_q.next_pos   = host_req.wdata[`CWS_FIRST_MSB:0];
            next_q.st         = cws_pkg::CWS_FETCH;
            next_q.tick       = 14'h0000;
            next_q.units      = 16'h0000;
          end
        end
      end
      cws_pkg::CWS_FETCH: begin
        next_q.seq_last_step_pos = q.next_pos;
        next_q.cur  = fetched;
        next_q.goal = 16'(17'h00001 << fetched.wait_code) + `CWS_UNIT_BASE;
        if (q.next_pos > `CWS_ROM_LAST) begin
          // Reserved location: stop without writing
          next_q.st         = cws_pkg::CWS_IDLE;
          next_q.running    = 1'b0;
          next_q.seq_go_cmd = 1'b0;
        end else begin
          next_q.st = cws_pkg::CWS_READ;
        end
      end
      cws_pkg::CWS_READ: begin
        // Fetch the current contents of the target register
        next_q.bank.rd   = 1'b1;
        next_q.bank.addr = q.cur.target;
        next_q.st        = cws_pkg::CWS_MODIFY;
      end
      cws_pkg::CWS_MODIFY: begin
        // Bank read data arrives one cycle after the read strobe
        next_q.st = cws_pkg::CWS_WRITE;
      end
      cws_pkg::CWS_WRITE: begin
        // Replace only the selected field; unused value MSBs are dropped
        next_q.bank.wr    = 1'b1;
        next_q.bank.addr  = q.cur.target;
        next_q.bank.wdata = (bank_rdata & ~field_mask(q.cur.width, q.cur.field_lsb)) |
                            (16'(q.cur.value) << q.cur.field_lsb &
                             field_mask(q.cur.width, q.cur.field_lsb));
        next_q.st         = cws_pkg::CWS_WAIT;
      end
      cws_pkg::CWS_WAIT: begin
        if (step_done) begin
          if (q.cur.end_flag) begin
            next_q.st         = cws_pkg::CWS_IDLE;
            next_q.running    = 1'b0;
            next_q.seq_go_cmd = 1'b0;
          end else begin
            next_q.next_pos = q.seq_last_step_pos + 6'h01;
            next_q.st       = cws_pkg::CWS_FETCH;
            next_q.tick     = 14'h0000;
            next_q.units    = 16'h0000;
          end
        end
      end
    endcase
    // Abort ends any step at once, even one mid-write
    if (wr_command && host_req.wdata[`CWS_ABORT_BIT] && q.running) begin
      next_q.st         = cws_pkg::CWS_IDLE;
      next_q.running    = 1'b0;
      next_q.seq_go_cmd = 1'b0;
      next_q.bank.wr    = 1'b0;
      next_q.bank.rd    = 1'b0;
    end
    // Host read answer, zero for addresses outside this block
    next_q.rdata = 16'h0000;
    if (host_req.rd) begin
      unique case (host_req.addr)
        `CWS_ADDR_SETUP:    next_q.rdata = 16'({q.sequencer_on, 3'h0, q.step_ram_write_pos});
        `CWS_ADDR_STEP_A:   next_q.rdata = {1'b0, q.step_a};
        `CWS_ADDR_STEP_B:   next_q.rdata = {1'b0, q.step_b};
        `CWS_ADDR_COMMAND:  next_q.rdata = 16'({q.seq_go_cmd, 2'h0, q.seq_first_step});
        `CWS_ADDR_BUSY:     next_q.rdata = 16'(q.running);
        `CWS_ADDR_POSITION: next_q.rdata = 16'(q.seq_last_step_pos);
        default:            next_q.rdata = 16'h0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q                    <= '0;
      q.st                 <= cws_pkg::CWS_IDLE;
      q.step_ram_write_pos <= `CWS_RST_WRPOS;
      q.step_a             <= `CWS_RST_STEP;
      q.step_b             <= `CWS_RST_STEP;
      q.seq_first_step     <= `CWS_RST_INDEX;
      q.seq_last_step_pos  <= `CWS_RST_INDEX;
      q.goal               <= `CWS_UNIT_BASE;
    end else begin
      q <= next_q;
    end
  end

  // RAM fill: a step register write copies the new word into the selected slot
  always_ff @(posedge clk) begin
    if (wr_step_a) begin
      step_ram[q.step_ram_write_pos] <= pack_step(host_req.wdata[14:0], q.step_b);
    end else if (wr_step_b) begin
      step_ram[q.step_ram_write_pos] <= pack_step(q.step_a, host_req.wdata[14:0]);
    end
  end

  // Outputs straight from the state register
  always_comb begin
    host_rdata       = q.rdata;
    bank_req         = q.bank;
    seq_running_flag = q.running;
  end

endmodule : cws_sequencer

/* File: cws_sequencer_checker.sv */
// Port assertions for the control write sequencer
`timescale 1ns/10ps
module cws_sequencer_checker #(
  parameter int unsigned UNIT_CYCLES = 4  // Cycles per delay unit
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire cws_pkg::cws_host_req_s host_req,
  input wire logic [15:0]            host_rdata,
  input wire cws_pkg::cws_bank_req_s bank_req,
  input wire logic [15:0]            bank_rdata,
  input wire logic                   seq_running_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic        en_q;  // Shadow of the enable bit
  logic [15:0] gap;   // Cycles since the last bank read
  logic        seen;  // A bank read happened in this run
  wire cmd_wr    = host_req.wr && host_req.addr == 8'h49;  // Command write
  wire abort_now = cmd_wr && host_req.wdata[9];            // Abort request
  wire outside   = host_req.addr < 8'h46 || host_req.addr > 8'h4b;
  // Enable shadow and step spacing; gap saturates so long idles cannot wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
      gap  <= 16'h0000;
      seen <= 1'b0;
    end else begin
      if (host_req.wr && host_req.addr == 8'h46 && !seq_running_flag) en_q <= host_req.wdata[8];
      if (bank_req.rd) gap <= 16'h0001;
      else if (gap != 16'hffff) gap <= gap + 16'h0001;
      seen <= seq_running_flag && (seen || bank_req.rd);
    end
  end
  AST_START_BUSY: assert property (cmd_wr && host_req.wdata[8] && !host_req.wdata[9] && en_q &&
    !seq_running_flag |=> seq_running_flag) else $error("start did not raise busy");
  AST_NO_START_OFF: assert property (cmd_wr && !en_q && !seq_running_flag
    |=> !seq_running_flag) else $error("start taken while disabled");
  AST_ABORT: assert property (seq_running_flag && abort_now
    |=> !seq_running_flag && !bank_req.wr && !bank_req.rd) else $error("abort not immediate");
  AST_WR_CAUSE: assert property (bank_req.wr |-> $past(bank_req.rd, 2) ||
    ($past(host_req.wr) && !$past(seq_running_flag))) else $error("bank write without cause");
  AST_PASS: assert property (!seq_running_flag && host_req.wr && outside |=> bank_req.wr &&
    bank_req.addr == $past(host_req.addr) && bank_req.wdata == $past(host_req.wdata))
    else $error("idle host write not passed on");
  AST_RMW: assert property (bank_req.rd ##1 (seq_running_flag && !abort_now)
    |=> bank_req.wr && bank_req.addr == $past(bank_req.addr, 2)) else $error("no write back");
  AST_RD_BUSY: assert property (bank_req.rd |-> seq_running_flag)
    else $error("bank read while idle");
  AST_BUSY_READ: assert property (host_req.rd && host_req.addr == 8'h4a
    |=> host_rdata == {15'h0000, $past(seq_running_flag)}) else $error("busy readback wrong");
  AST_RDATA_PULSE: assert property (host_rdata != 16'h0000 |-> $past(host_req.rd))
    else $error("read data without read");
  AST_STEP_TIME: assert property (bank_req.rd && seen |-> gap % UNIT_CYCLES == 0 &&
    $onehot(gap / UNIT_CYCLES - 8)) else $error("step period wrong");
  cover property (seq_running_flag && abort_now);
  cover property ($fell(seq_running_flag));
  cover property (bank_req.rd && seen);
endmodule : cws_sequencer_checker

bind cws_sequencer cws_sequencer_checker #(.UNIT_CYCLES(UNIT_CYCLES)) chk_u (
  .clk(clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
  .bank_req(bank_req), .bank_rdata(bank_rdata), .seq_running_flag(seq_running_flag));

/* File: cws_bank_model.sv */
// Control register bank model on the sequencer's far side
`timescale 1ns/10ps
module cws_bank_model (
  input  wire logic                   clk,
  input  wire cws_pkg::cws_bank_req_s bank_req,
  output logic [15:0]                 bank_rdata
);
  logic [15:0] mem [0:255];  // Register contents, read by the bench
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
    bank_rdata = 16'h5a5a;
  end
  // Data one cycle after a read; toggled otherwise so stale data never looks valid
  always @(posedge clk) begin
    if (bank_req.wr) mem[bank_req.addr] <= bank_req.wdata;
    if (bank_req.rd) bank_rdata <= mem[bank_req.addr];
    else bank_rdata <= ~bank_rdata;
  end
endmodule : cws_bank_model

/* File: test_control_write_sequencer.sv */
// Self-checking bench for the control write sequencer
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_control_write_sequencer;
  cws_pkg::cws_host_req_s host_req;          // Host request
  cws_pkg::cws_bank_req_s bank_req;          // Bank request
  logic                   clk, rst;          // Clock and reset
  logic [15:0]            host_rdata, bank_rdata, rv;
  logic                   seq_running_flag;  // Busy level
  int                     failures, n_compared, busy_cycles;
  // Short delay unit keeps each step tens of cycles long
  cws_sequencer #(.UNIT_CYCLES(4)) dut_u (.clk(clk), .rst(rst), .host_req(host_req),
    .host_rdata(host_rdata), .bank_req(bank_req), .bank_rdata(bank_rdata),
    .seq_running_flag(seq_running_flag));
  cws_bank_model bank_u (.clk(clk), .bank_req(bank_req), .bank_rdata(bank_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Busy length, sampled before each edge's update lands
  always @(posedge clk) if (seq_running_flag) busy_cycles++;
  task automatic host_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); #1;
    host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk); #1;
    host_req.wr = 1'b0;
  endtask : host_wr
  // Read data stands only in the cycle after the taking edge
  task automatic chk_rd(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk); #1;
    host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk); #1;
    host_req.rd = 1'b0;
    rv = host_rdata;
    `CHK(n, e, rv)
  endtask : chk_rd
  task automatic load_step(input logic [4:0] p, input logic [15:0] a, input logic [15:0] b);
    host_wr(8'h46, {11'h008, p});
    host_wr(8'h47, a);
    host_wr(8'h48, b);
  endtask : load_step
  task automatic wait_idle;
    for (int i = 0; i < 2000 && seq_running_flag !== 1'b0; i++) begin
      @(posedge clk); #1;
    end
    // A sequence that never ends counts as a mismatch here, not only at the watchdog
    `CHK("wait_idle", 1'b0, seq_running_flag)
  endtask : wait_idle
  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    host_req = '0;
    rst = 1'b1;
    failures = 0;
    n_compared = 0;
    busy_cycles = 0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    chk_rd("busy_reset", 8'h4a, 16'h0000);
    chk_rd("command_reset", 8'h49, 16'h0000);
    chk_rd("position_reset", 8'h4b, 16'h0000);
    chk_rd("unmapped", 8'h30, 16'h0000);
    host_wr(8'h10, 16'h00ff);
    host_wr(8'h00, 16'h0003);
    `CHK("pass_through", 16'h00ff, bank_u.mem[8'h10])
    // Four bits at bit 4, then one bit at bit 15 with the end flag
    load_step(5'h00, 16'h3410, 16'h000a);
    load_step(5'h01, 16'h0f11, 16'h4101);
    chk_rd("setup_read", 8'h46, 16'h0101);
    chk_rd("step_b_read", 8'h48, 16'h4101);
    busy_cycles = 0;
    host_wr(8'h49, 16'h0100);
    chk_rd("busy_running", 8'h4a, 16'h0001);
    host_wr(8'h10, 16'hffff);
    wait_idle();
    `CHK("rmw_field", 16'h00af, bank_u.mem[8'h10])
    `CHK("end_step", 16'h8000, bank_u.mem[8'h11])
    `CHK("step_time", 76, busy_cycles)
    chk_rd("start_cleared", 8'h49, 16'h0000);
    chk_rd("position_last", 8'h4b, 16'h0001);
    host_wr(8'h49, 16'h0120);
    wait_idle();
    `CHK("rom_step", 16'h0002, bank_u.mem[8'h00])
    chk_rd("rom_cleared", 8'h49, 16'h0020);
    chk_rd("position_rom", 8'h4b, 16'h0020);
    host_wr(8'h49, 16'h013f);
    wait_idle();
    chk_rd("position_reserved", 8'h4b, 16'h003f);
    // Abort in the first cycle of the first step's wait, after its write
    host_wr(8'h49, 16'h0100);
    repeat (3) @(posedge clk);
    host_wr(8'h49, 16'h0200);
    `CHK("abort_busy", 1'b0, seq_running_flag)
    chk_rd("abort_cleared", 8'h49, 16'h0000);
    host_wr(8'h12, 16'h1234);
    chk_rd("busy_after_abort", 8'h4a, 16'h0000);
    `CHK("port_returned", 16'h1234, bank_u.mem[8'h12])
    // Start and abort in one write: abort wins, nothing runs
    host_wr(8'h49, 16'h0300);
    `CHK("abort_wins", 1'b0, seq_running_flag)
    host_wr(8'h46, 16'h0000);
    host_wr(8'h49, 16'h0100);
    `CHK("no_start_disabled", 1'b0, seq_running_flag)
    tally_and_finish();
  end
endmodule : test_control_write_sequencer
